// *** src/pao_pkg.sv ***
// Constants shared by the converter output port and its code FIFO.
// Assumes one 25 MHz system clock and digital stand-ins for analog levels.
package pao_pkg;
  localparam int          CODE_W         = 8;
  localparam int          LEVEL_W        = 12;
  localparam logic [7:0]  CODE_ZERO      = 8'h00;
  localparam logic [7:0]  CODE_FULL      = 8'hff;
  localparam int          SCALE_W        = 20;
  localparam logic [19:0] CODE_SCALE     = 20'h000ff;
  // Latency of 2.5 conversion periods counted as rising edges after the sample fall
  localparam int          PIPE_RISES     = 3;
  localparam int          MAX_RATE_MSPS  = 30;
  localparam int          SYS_CLK_MHZ    = 25;
  localparam int          FIFO_DEPTH     = 16;
  localparam int          FIFO_AW        = 4;
  localparam logic [4:0]  FIFO_CNT_RESET = 5'h00;
  localparam logic [3:0]  PTR_RESET      = 4'h0;
endpackage

// *** src/pao_fifo.sv ***
// Code FIFO with width and depth parameters and registered read data.
// Assumes synchronous valid/ready handshakes on both sides.
`timescale 1ns/1ps
`default_nettype none
module pao_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign wr_ready_out = (count != (AW+1)'(DEPTH));
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = (count != '0) && (!rd_valid_out || rd_ready_in);

  // Storage
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered read stage
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out  <= '0;
      rd_valid_out <= 1'b0;
    end else if (pop) begin
      rd_data_out  <= mem[rd_ptr];
      rd_valid_out <= 1'b1;
    end else if (rd_ready_in) begin
      rd_valid_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** src/pao_top.sv ***
// Digital side of an 8-bit pipelined sampling converter and its output port.
// Assumes the conversion clock and enable are synchronous to sys_clk_in.
//
// Behaviour
// - Sample input on conversion clock falling edge
// - Code appears 2.5 cycles after sampling
// - Convert continuously while conversion clock toggles
// - Enable low drives data pins
// - Enable high releases all data pins
// - Below bottom reference gives all zeros
// - Above top reference gives all ones
// - Fresh code every cycle, fixed lag
// - Output bus updates after rising edge
// - In-range inputs resolve to eight bits
`timescale 1ns/1ps
`default_nettype none
module pao_top (
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic                        conv_clk_in,
  input  wire logic                        oe_n_in,
  input  wire logic [pao_pkg::LEVEL_W-1:0] analog_level_in,
  input  wire logic [pao_pkg::LEVEL_W-1:0] top_reference_level_in,
  input  wire logic [pao_pkg::LEVEL_W-1:0] bottom_reference_level_in,
  output logic      [pao_pkg::CODE_W-1:0]  code_out,
  output logic      [pao_pkg::CODE_W-1:0]  code_oe_out,
  output logic      [pao_pkg::CODE_W-1:0]  stream_data_out,
  output logic                             stream_valid_out,
  input  wire logic                        stream_ready_in,
  output logic                             overrun_out
);
  import pao_pkg::*;

  logic              conv_clk_prev;
  logic              fall;
  logic              rise;
  logic [CODE_W-1:0] next_code;
  logic [CODE_W-1:0] stage [PIPE_RISES];
  logic              stage_vld [PIPE_RISES];
  logic              code_new;
  logic              fifo_ready;

  // Quantise a level against the reference ladder
  function automatic logic [CODE_W-1:0] quantise(
    input logic [LEVEL_W-1:0] vin,
    input logic [LEVEL_W-1:0] vrb,
    input logic [LEVEL_W-1:0] vrt
  );
    logic [SCALE_W-1:0] num;
    logic [SCALE_W-1:0] span;
    logic [SCALE_W-1:0] q;
    num  = '0;
    span = '0;
    q    = '0;
    if (vin < vrb) begin
      quantise = CODE_ZERO;
    end else if (vin > vrt) begin
      quantise = CODE_FULL;
    end else if (vrt == vrb) begin
      quantise = CODE_ZERO;
    end else begin
      num      = SCALE_W'(vin - vrb) * CODE_SCALE;
      span     = SCALE_W'(vrt - vrb);
      q        = num / span;
      quantise = q[CODE_W-1:0];
    end
  endfunction

  // Edge detection on the conversion clock
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      conv_clk_prev <= 1'b0;
    end else begin
      conv_clk_prev <= conv_clk_in;
    end
  end

  assign fall      = conv_clk_prev && !conv_clk_in;
  assign rise      = !conv_clk_prev && conv_clk_in;
  assign next_code = quantise(analog_level_in, bottom_reference_level_in,
                              top_reference_level_in);

  // Sample and hold stage
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage[0]     <= CODE_ZERO;
      stage_vld[0] <= 1'b0;
    end else if (fall) begin
      stage[0]     <= next_code;
      stage_vld[0] <= 1'b1;
    end
  end

  // Pipeline advancing on each rising edge
  genvar gi;
  generate
    for (gi = 1; gi < PIPE_RISES; gi++) begin : g_pipe
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          stage[gi]     <= CODE_ZERO;
          stage_vld[gi] <= 1'b0;
        end else if (rise) begin
          stage[gi]     <= stage[gi-1];
          stage_vld[gi] <= stage_vld[gi-1];
        end
      end
    end
  endgenerate

  // Output bus register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      code_out <= CODE_ZERO;
      code_new <= 1'b0;
    end else begin
      code_new <= rise && stage_vld[PIPE_RISES-1];
      if (rise) begin
        code_out <= stage[PIPE_RISES-1];
      end
    end
  end

  // Pin drive enables
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      code_oe_out <= CODE_ZERO;
    end else begin
      code_oe_out <= oe_n_in ? CODE_ZERO : CODE_FULL;
    end
  end

  // Dropped codes when the stream FIFO is full
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      overrun_out <= 1'b0;
    end else if (code_new && !fifo_ready) begin
      overrun_out <= 1'b1;
    end
  end

  pao_fifo #(
    .WIDTH (CODE_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_in       (sys_clk_in),
    .rst_b_in     (rst_b_in),
    .wr_data_in   (code_out),
    .wr_valid_in  (code_new),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (stream_data_out),
    .rd_valid_out (stream_valid_out),
    .rd_ready_in  (stream_ready_in)
  );

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_clamp_low: assert property (
    fall && (analog_level_in < bottom_reference_level_in) |=> stage[0] == CODE_ZERO)
    else $error("Low clamp code wrong");
  a_clamp_high: assert property (
    fall && (analog_level_in > top_reference_level_in) |=> stage[0] == CODE_FULL)
    else $error("High clamp code wrong");
  a_bottom_is_zero: assert property (
    fall && (analog_level_in == bottom_reference_level_in) |=> stage[0] == CODE_ZERO)
    else $error("Bottom reference not zero code");
  a_top_is_full: assert property (
    fall && (analog_level_in == top_reference_level_in) &&
    (top_reference_level_in > bottom_reference_level_in) |=> stage[0] == CODE_FULL)
    else $error("Top reference not full code");
  a_sample_hold: assert property (
    !fall |=> $stable(stage[0]))
    else $error("Held sample changed without fall");
  a_bus_update: assert property (
    !rise |=> $stable(code_out))
    else $error("Bus changed away from rise");
  a_pipe_latency: assert property (
    rise |=> code_out == $past(stage[PIPE_RISES-1]))
    else $error("Output stage latency wrong");
  a_fresh_code: assert property (
    rise |=> stage[1] == $past(stage[0]))
    else $error("Pipeline did not advance");
  a_drive_on: assert property (
    !oe_n_in |=> code_oe_out == CODE_FULL)
    else $error("Pins not driven with enable low");
  a_drive_off: assert property (
    oe_n_in |=> code_oe_out == CODE_ZERO)
    else $error("Pins driven with enable high");

  a_fall_loads: assert property (
    fall |=> stage_vld[0])
    else $error("Sample not loaded on fall");
  a_stage_advance: assert property (
    rise |=> stage[PIPE_RISES-1] == $past(stage[PIPE_RISES-2]))
    else $error("Last stage did not advance");
  a_code_push: assert property (
    rise && stage_vld[PIPE_RISES-1] |=> code_new)
    else $error("Fresh code not pushed");
  a_push_only_rise: assert property (
    !rise |=> !code_new)
    else $error("Code pushed without rise");

  a_stream_hold: assert property (
    stream_valid_out && !stream_ready_in |=> stream_valid_out && $stable(stream_data_out))
    else $error("Stream head changed while stalled");
  a_overrun_set: assert property (
    code_new && !fifo_ready |=> overrun_out)
    else $error("Dropped code not flagged");
  a_overrun_sticky: assert property (
    overrun_out |=> overrun_out)
    else $error("Overrun flag cleared");

  c_sample: cover property (fall ##[1:20] rise);
  c_clamp_high: cover property (fall && analog_level_in > top_reference_level_in);
  c_overrun: cover property ($rose(overrun_out));
  c_enable_toggle: cover property (!oe_n_in ##1 oe_n_in);
  c_stream_stall: cover property (stream_valid_out && !stream_ready_in ##1 stream_valid_out);
endmodule
`default_nettype wire

// *** test/pao_capture_model.sv ***
// Capture-side model: makes the conversion clock and takes stream codes.
// Assumes the bench steers run and stall from the system clock.
`timescale 1ns/1ps
`default_nettype none
module pao_capture_model #(
  parameter int HALF = 2
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  input  wire logic run_in,
  input  wire logic stall_in,
  input  wire logic valid_in,
  output logic      conv_clk_out,
  output logic      ready_out,
  output logic      pop_out
);
  logic [3:0] ph;
  logic [2:0] boot;
  // Two full periods after start, then park low when stopped
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ph           <= 4'h0;
      boot         <= 3'h4;
      conv_clk_out <= 1'b0;
    end else if (run_in || boot != 3'h0 || conv_clk_out) begin
      if (ph == 4'(HALF - 1)) begin
        ph           <= 4'h0;
        conv_clk_out <= !conv_clk_out;
        if (boot != 3'h0) boot <= boot - 3'h1;
      end else begin
        ph <= ph + 4'h1;
      end
    end
  end
  assign ready_out = !stall_in;
  assign pop_out   = valid_in && ready_out;
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the converter output port.
// Assumes the package constants and a 25 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pao_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        oe_n;
  logic        run;
  logic        stall;
  logic        cclk;
  logic        rdy;
  logic        pop;
  logic        sval;
  logic        ovr;
  logic [11:0] lvl;
  logic [11:0] top;
  logic [11:0] bot;
  logic [7:0]  code;
  logic [7:0]  oe;
  logic [7:0]  sdat;
  logic [7:0]  held;
  int          bad_count;
  int          compares;
  int          n;
  pao_top pao_top_i (
    .sys_clk_in(clk), .rst_b_in(rst_b), .conv_clk_in(cclk), .oe_n_in(oe_n),
    .analog_level_in(lvl), .top_reference_level_in(top), .bottom_reference_level_in(bot),
    .code_out(code), .code_oe_out(oe), .stream_data_out(sdat), .stream_valid_out(sval),
    .stream_ready_in(rdy), .overrun_out(ovr));
  pao_capture_model pao_capture_model_i (
    .sys_clk_in(clk), .rst_b_in(rst_b), .run_in(run), .stall_in(stall),
    .valid_in(sval), .conv_clk_out(cclk), .ready_out(rdy), .pop_out(pop));
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] quant(input logic [11:0] v);
    if (v < bot) return CODE_ZERO;
    if (v > top) return CODE_FULL;
    if (top == bot) return CODE_ZERO;
    return 8'(((20'(v) - 20'(bot)) * CODE_SCALE) / (20'(top) - 20'(bot)));
  endfunction
  // Apply a level, time the new code and check its value
  task automatic conv(input logic [11:0] v);
    logic [7:0] e;
    e = quant(v);
    @(posedge clk) lvl <= v;
    #1;
    n = 0;
    while (code !== e && n < 40) begin
      tick();
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      $display("ERROR t=%0t no new code in time", $time);
      report_and_stop();
    end
    chk(code, e);
    chk({7'h0, n inside {[11:14]}}, 8'h01);
    chk({7'h0, cclk}, 8'h01);
  endtask
  // Count handshakes in the current cycle and the ones after it
  task automatic count_pops(input int cyc, input logic look);
    n = 0;
    repeat (cyc) begin
      if (pop) n++;
      if (pop && look) chk(sdat, CODE_ZERO);
      tick();
    end
  endtask
  task automatic report_and_stop();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Quiet outputs just after reset
  task automatic after_reset();
    tick();
    chk({6'h00, sval, ovr}, 8'h00);
    chk(oe, 8'h00);
  endtask
  // Set the enable and check the pin drive
  task automatic enable_set(input logic off, input logic [7:0] e);
    @(posedge clk) oe_n <= off;
    tick();
    chk(oe, e);
  endtask
  // One code per conversion period on the stream
  task automatic stream_run();
    count_pops(40, 1'b1);
    chk({7'h0, n inside {[9:11]}}, 8'h01);
  endtask
  // Stopped clock gives no new codes
  task automatic stop_clock();
    @(posedge clk) run <= 1'b0;
    repeat (8) tick();
    held = code;
    count_pops(40, 1'b0);
    chk(8'(n), 8'h00);
    chk(code, held);
  endtask
  // Stalled consumer fills the FIFO, then drains it
  task automatic stall_overrun();
    @(posedge clk) stall <= 1'b1;
    run <= 1'b1;
    repeat (100) tick();
    chk({6'h00, sval, ovr}, 8'h03);
    @(posedge clk) run <= 1'b0;
    repeat (8) tick();
    @(posedge clk) stall <= 1'b0;
    #1;
    count_pops(40, 1'b1);
    chk(8'(n), 8'h11);
    chk({7'h0, sval}, 8'h00);
  endtask
  initial begin
    bad_count = 0;
    compares = 0;
    rst_b <= 1'b0;
    {oe_n, run, stall} <= 3'b110;
    lvl <= 12'h100;
    top <= 12'h4ff;
    bot <= 12'h100;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    after_reset();
    enable_set(1'b0, CODE_FULL);
    conv(12'h600);
    conv(12'h050);
    conv(12'h300);
    conv(12'h4ff);
    conv(12'h100);
    stream_run();
    stop_clock();
    stall_overrun();
    enable_set(1'b1, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
